/* File: shared/acq_pkg.sv */
// Constants and carrier types of the cell queue servicing controller.
package acq_pkg;
    // Device side data ports and interrupt registers.
    localparam logic [31:0] TXQ_BASE = 32'h3d00_0000;
    localparam logic [31:0] RXQ_BASE = 32'h3c00_0000;
    localparam logic [31:0] IRQ_EN_ADDR = 32'h3c80_0000;
    localparam logic [31:0] IRQ_PEND_ADDR = 32'h3c80_0004;
    localparam int RX_BIT = 16;
    localparam int TX_BIT = 0;
    // Cell sizes in 32-bit words.
    localparam logic [4:0] WORDS_STD = 5'h0e;
    localparam logic [4:0] WORDS_MID = 5'h0f;
    localparam logic [4:0] WORDS_MAX = 5'h10;
    // Controller register map.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_TXCNT = 8'h08;
    localparam logic [7:0] REG_RXACK = 8'h0c;
    localparam logic [1:0] WIN_TXBUF = 2'h1;
    localparam logic [1:0] WIN_RXBUF = 2'h2;
    // Control fields and reset values.
    localparam int CTRL_TX_EN = 0;
    localparam int CTRL_RX_EN = 1;
    localparam int CTRL_IRQ = 2;
    localparam int CTRL_SIZE = 3;
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [7:0] CNT_RST = 8'h00;
    // Status fields and synchroniser depth.
    localparam int STAT_RX_FULL = 0;
    localparam int STAT_BUSY = 1;
    localparam int STAT_TX_LEFT = 8;
    localparam int STAT_RX_CNT = 16;
    localparam int SYNC_STAGES = 3;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } acq_qbus_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } acq_sw_t;
endpackage

/* File: core/acq_host.sv */
// Controller that services the device transmit and receive cell queues.
`timescale 1ns/10ps
// Overview of operation
// - One event moves exactly one cell.
// - Cell size is 14, 15 or 16 words.
// - Queue port accesses are whole 32-bit words.
// - Word elements, auto-increment, frame-synchronised transfers.
// - Transmit cells written starting at transmit port.
// - Receive cells read starting at receive port.
// - Transmit element count equals configured cell size.
// - Receive element count equals configured cell size.
// - Service routine reads pending, moves cell, clears.
// - Event-driven servicing preferred over interrupt servicing.
module acq_host #(
    parameter int BUF_WORDS = 16
) (
    // Clock and reset.
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // Software register port.
    input wire acq_pkg::acq_sw_t SW,
    output logic [31:0] SW_RDATA,
    // Device queue and register bus.
    output acq_pkg::acq_qbus_t Q_BUS,
    input wire logic [31:0] Q_RDATA,
    // Device event and interrupt pins.
    input wire logic TX_QUEUE_EVENT,
    input wire logic RX_QUEUE_EVENT,
    input wire logic QUEUE_CPU_INTERRUPT
);
    import acq_pkg::*;

    typedef enum logic [6:0] {
        ST_INIT = 7'h01,
        ST_IDLE = 7'h02,
        ST_TX = 7'h04,
        ST_RX = 7'h08,
        ST_PRD = 7'h10,
        ST_PCAP = 7'h20,
        ST_CLR = 7'h40
    } acq_state_t;

    acq_state_t state_r, state_nxt;
    logic [3:0] idx_r;
    logic svc_rx_r;
    logic [4:0] ctrl_r;
    logic dirty_r;
    logic [7:0] tx_left_r;
    logic [7:0] rx_cnt_r;
    logic rx_full_r;
    logic [31:0] sw_rdata_r;
    logic [31:0] tx_buf [BUF_WORDS];
    logic [31:0] rx_buf [BUF_WORDS];
    acq_qbus_t q_r;
    logic rd_d_r;
    logic rd_pend_r;
    logic [3:0] rd_idx_r;
    logic [2:0] s1_r, s2_r, s3_r, lvl_r;
    logic tx_evt, rx_evt, irq_lvl;
    logic [4:0] words;
    logic [4:0] cell_words_r;
    logic last;
    logic rd_busy;
    logic go_tx, go_rx, go_prd;
    logic pend_vld;
    logic cap_last;

    // Pins are sampled by three flops; a change counts once stages two and three agree.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s1_r <= 3'h0;
            s2_r <= 3'h0;
            s3_r <= 3'h0;
            lvl_r <= 3'h0;
        end else begin
            s1_r <= {QUEUE_CPU_INTERRUPT, RX_QUEUE_EVENT, TX_QUEUE_EVENT};
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < SYNC_STAGES; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    lvl_r[i] <= s3_r[i];
                end
            end
        end
    end

    assign tx_evt = lvl_r[0];
    assign rx_evt = lvl_r[1];
    assign irq_lvl = lvl_r[2];

    always_comb begin
        case (ctrl_r[CTRL_SIZE +: 2])
            2'h0: words = WORDS_STD;
            2'h1: words = WORDS_MID;
            default: words = WORDS_MAX;
        endcase
    end

    assign last = ({1'b0, idx_r} == cell_words_r - 5'h01);
    assign rd_busy = q_r.rd | rd_d_r;
    assign pend_vld = rd_d_r & rd_pend_r;
    assign cap_last = rd_d_r & !rd_pend_r & ({1'b0, rd_idx_r} == cell_words_r - 5'h01);

    // Start decisions; a cell only starts on a live event level or pending bit.
    always_comb begin
        go_tx = 1'b0;
        go_rx = 1'b0;
        go_prd = 1'b0;
        if (state_r == ST_IDLE && !dirty_r) begin
            if (ctrl_r[CTRL_IRQ]) begin
                go_prd = irq_lvl & !rd_busy;
            end else if (ctrl_r[CTRL_TX_EN] && tx_evt && tx_left_r != CNT_RST) begin
                go_tx = 1'b1;
            end else if (ctrl_r[CTRL_RX_EN] && rx_evt && !rx_full_r && !rd_busy) begin
                go_rx = 1'b1;
            end
        end else if (state_r == ST_PCAP && pend_vld) begin
            if (Q_RDATA[TX_BIT] && ctrl_r[CTRL_TX_EN] && tx_left_r != CNT_RST) begin
                go_tx = 1'b1;
            end else if (Q_RDATA[RX_BIT] && ctrl_r[CTRL_RX_EN] && !rx_full_r) begin
                go_rx = 1'b1;
            end
        end
    end

    always_comb begin
        case (state_r)
            ST_INIT: state_nxt = ST_IDLE;
            ST_IDLE: begin
                if (dirty_r) begin
                    state_nxt = ST_INIT;
                end else if (go_prd) begin
                    state_nxt = ST_PRD;
                end else if (go_tx) begin
                    state_nxt = ST_TX;
                end else if (go_rx) begin
                    state_nxt = ST_RX;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_TX, ST_RX: begin
                if (!last) begin
                    state_nxt = state_r;
                end else if (ctrl_r[CTRL_IRQ]) begin
                    state_nxt = ST_CLR;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_PRD: state_nxt = ST_PCAP;
            ST_PCAP: begin
                if (!pend_vld) begin
                    state_nxt = ST_PCAP;
                end else if (go_tx) begin
                    state_nxt = ST_TX;
                end else if (go_rx) begin
                    state_nxt = ST_RX;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_CLR: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= ST_INIT;
            idx_r <= 4'h0;
            svc_rx_r <= 1'b0;
            cell_words_r <= WORDS_STD;
        end else begin
            state_r <= state_nxt;
            // The size is held for the whole cell, so a control write cannot stretch or cut it.
            if (go_tx || go_rx) begin
                cell_words_r <= words;
            end
            if (state_r == ST_TX || state_r == ST_RX) begin
                idx_r <= idx_r + 4'h1;
            end else begin
                idx_r <= 4'h0;
            end
            if (go_tx) begin
                svc_rx_r <= 1'b0;
            end else if (go_rx) begin
                svc_rx_r <= 1'b1;
            end
        end
    end

    // Device bus: one registered word access per cycle, never both strobes.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            q_r <= '0;
        end else begin
            q_r <= '0;
            case (state_r)
                ST_INIT: begin
                    q_r.wr <= 1'b1;
                    q_r.addr <= IRQ_EN_ADDR;
                    q_r.wdata[RX_BIT] <= ctrl_r[CTRL_IRQ] & ctrl_r[CTRL_RX_EN];
                    q_r.wdata[TX_BIT] <= ctrl_r[CTRL_IRQ] & ctrl_r[CTRL_TX_EN];
                end
                ST_TX: begin
                    q_r.wr <= 1'b1;
                    q_r.addr <= TXQ_BASE + {26'h0, idx_r, 2'h0};
                    q_r.wdata <= tx_buf[idx_r];
                end
                ST_RX: begin
                    q_r.rd <= 1'b1;
                    q_r.addr <= RXQ_BASE + {26'h0, idx_r, 2'h0};
                end
                ST_PRD: begin
                    q_r.rd <= 1'b1;
                    q_r.addr <= IRQ_PEND_ADDR;
                end
                ST_CLR: begin
                    q_r.wr <= 1'b1;
                    q_r.addr <= IRQ_PEND_ADDR;
                    q_r.wdata[RX_BIT] <= svc_rx_r;
                    q_r.wdata[TX_BIT] <= !svc_rx_r;
                end
                default: q_r <= '0;
            endcase
        end
    end

    assign Q_BUS = q_r;

    // Read data returns one cycle after the strobe leaves this block.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_d_r <= 1'b0;
            rd_pend_r <= 1'b0;
            rd_idx_r <= 4'h0;
        end else begin
            rd_d_r <= q_r.rd;
            rd_pend_r <= (q_r.addr == IRQ_PEND_ADDR);
            rd_idx_r <= q_r.addr[5:2];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (rd_d_r && !rd_pend_r) begin
            rx_buf[rd_idx_r] <= Q_RDATA;
        end
        if (SW.wr && SW.addr[7:6] == WIN_TXBUF) begin
            tx_buf[SW.addr[5:2]] <= SW.wdata;
        end
    end

    // Software registers; a finished receive cell wins over its acknowledge.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_r <= CTRL_RST;
            dirty_r <= 1'b1;
            tx_left_r <= CNT_RST;
            rx_cnt_r <= CNT_RST;
            rx_full_r <= 1'b0;
        end else begin
            if (SW.wr && SW.addr == REG_CTRL) begin
                ctrl_r <= SW.wdata[4:0];
            end
            if (SW.wr && SW.addr == REG_CTRL) begin
                dirty_r <= 1'b1;
            end else if (state_r == ST_INIT) begin
                dirty_r <= 1'b0;
            end
            if (SW.wr && SW.addr == REG_TXCNT) begin
                tx_left_r <= SW.wdata[7:0];
            end else if (go_tx) begin
                tx_left_r <= tx_left_r - 8'h01;
            end
            if (cap_last) begin
                rx_full_r <= 1'b1;
                rx_cnt_r <= rx_cnt_r + 8'h01;
            end else if (SW.wr && SW.addr == REG_RXACK && SW.wdata[STAT_RX_FULL]) begin
                rx_full_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sw_rdata_r <= 32'h0;
        end else begin
            sw_rdata_r <= 32'h0;
            if (SW.rd) begin
                if (SW.addr == REG_CTRL) begin
                    sw_rdata_r <= {27'h0, ctrl_r};
                end else if (SW.addr == REG_STAT) begin
                    sw_rdata_r[STAT_RX_FULL] <= rx_full_r;
                    sw_rdata_r[STAT_BUSY] <= (state_r != ST_IDLE);
                    sw_rdata_r[STAT_TX_LEFT +: 8] <= tx_left_r;
                    sw_rdata_r[STAT_RX_CNT +: 8] <= rx_cnt_r;
                end else if (SW.addr[7:6] == WIN_TXBUF) begin
                    sw_rdata_r <= tx_buf[SW.addr[5:2]];
                end else if (SW.addr[7:6] == WIN_RXBUF) begin
                    sw_rdata_r <= rx_buf[SW.addr[5:2]];
                end
            end
        end
    end

    assign SW_RDATA = sw_rdata_r;

    // Checks; run counters measure each burst of queue accesses.
    logic tx_wr_q, rx_rd_q;
    logic [4:0] tx_run_r, rx_run_r;
    assign tx_wr_q = q_r.wr && q_r.addr[31:24] == TXQ_BASE[31:24];
    assign rx_rd_q = q_r.rd && q_r.addr[31:16] == RXQ_BASE[31:16];

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_run_r <= 5'h00;
            rx_run_r <= 5'h00;
        end else begin
            tx_run_r <= tx_wr_q ? tx_run_r + 5'h01 : 5'h00;
            rx_run_r <= rx_rd_q ? rx_run_r + 5'h01 : 5'h00;
        end
    end

    a_one_strobe: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        !(q_r.wr && q_r.rd) && q_r.addr[1:0] == 2'h0)
        else $error("queue bus access not a single aligned word");
    a_tx_start_addr: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_r == ST_TX && idx_r == 4'h0) |=> q_r.wr && q_r.addr == TXQ_BASE)
        else $error("transmit cell did not start at transmit port");
    a_rx_start_addr: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_r == ST_RX && idx_r == 4'h0) |=> q_r.rd && q_r.addr == RXQ_BASE)
        else $error("receive cell did not start at receive port");
    a_tx_cell_len: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        $fell(tx_wr_q) |-> tx_run_r == words)
        else $error("transmit burst length differs from cell size");
    a_rx_cell_len: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        $fell(rx_rd_q) |-> rx_run_r == words)
        else $error("receive burst length differs from cell size");
    a_tx_frame_sync: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_r == ST_IDLE && state_nxt == ST_TX) |-> tx_evt && !ctrl_r[CTRL_IRQ])
        else $error("transmit cell started without an event");
    a_pend_read: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_r == ST_PRD) |=> q_r.rd && q_r.addr == IRQ_PEND_ADDR ##2 state_r != ST_PCAP)
        else $error("pending register read not issued or not taken");
    a_clear_one_bit: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_r == ST_CLR) |=> q_r.wr && q_r.addr == IRQ_PEND_ADDR
        && (q_r.wdata[RX_BIT] ^ q_r.wdata[TX_BIT]))
        else $error("pending clear did not write a single one");
    a_enable_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (RST_N && state_r == ST_INIT) |=> q_r.wr && q_r.addr == IRQ_EN_ADDR
        && q_r.wdata[RX_BIT] == $past(ctrl_r[CTRL_IRQ] & ctrl_r[CTRL_RX_EN])
        && q_r.wdata[TX_BIT] == $past(ctrl_r[CTRL_IRQ] & ctrl_r[CTRL_TX_EN]))
        else $error("enable register write wrong");

    c_tx_cell: cover property (@(posedge CORE_CLK) disable iff (!RST_N) $fell(tx_wr_q));
    c_rx_cell: cover property (@(posedge CORE_CLK) disable iff (!RST_N) cap_last);
    c_irq_service: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
        state_r == ST_PCAP ##1 state_r == ST_RX);
endmodule

/* File: testbench/acq_dev_model.sv */
// Behavioural model of the cell queue device: events, interrupt registers and data ports.
`timescale 1ns/10ps
module acq_dev_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Controller bus.
    input wire acq_pkg::acq_qbus_t q_bus,
    output logic [31:0] q_rdata,
    // Queue state set by the bench.
    input wire logic tx_room,
    input wire logic rx_push,
    // Event and interrupt pins.
    output logic tx_evt,
    output logic rx_evt,
    output logic irq
);
    import acq_pkg::*;
    localparam logic [31:0] IRQ_MASK = 32'h0001_0001;
    logic [31:0] en_r;
    logic [31:0] pend_r;
    logic [31:0] pend_clr;
    logic [7:0] rx_cells_r;
    logic [7:0] rx_cells_nxt;
    logic [7:0] rx_seq_r;
    logic [3:0] tx_idx_r;
    logic [3:0] rx_idx_r;
    logic [31:0] tx_mem [16];
    int tx_words = 0;
    int rx_words = 0;
    int bad = 0;
    wire tx_hit = q_bus.wr && q_bus.addr[31:6] == TXQ_BASE[31:6];
    wire rx_hit = q_bus.rd && q_bus.addr[31:6] == RXQ_BASE[31:6];
    wire tx_first = tx_hit && q_bus.addr[5:0] == 6'h00;
    wire rx_first = rx_hit && q_bus.addr[5:0] == 6'h00;
    assign rx_cells_nxt = rx_cells_r + 8'(rx_push) - 8'(rx_first);
    assign pend_clr = (q_bus.wr && q_bus.addr == IRQ_PEND_ADDR) ? q_bus.wdata & IRQ_MASK : 32'h0;
    // One shared line, each queue gated by its own enable bit.
    assign irq = |(pend_r & en_r);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_evt <= 1'b0;
            rx_evt <= 1'b0;
            rx_cells_r <= 8'h00;
            rx_seq_r <= 8'h00;
        end else begin
            tx_evt <= tx_room && !tx_first;
            rx_evt <= rx_cells_nxt != 8'h00 && !rx_first;
            rx_cells_r <= rx_cells_nxt;
            if (rx_first) begin
                rx_seq_r <= rx_seq_r + 8'h01;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_r <= 32'h0;
            pend_r <= 32'h0;
        end else begin
            if (q_bus.wr && q_bus.addr == IRQ_EN_ADDR) begin
                en_r <= q_bus.wdata & IRQ_MASK;
            end
            pend_r <= (pend_r & ~pend_clr) | {15'h0, rx_evt, 15'h0, tx_evt};
        end
    end
    // A released bus shows a pattern that changes every cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_rdata <= 32'h0;
        end else if (q_bus.rd) begin
            q_rdata <= q_bus.addr == IRQ_EN_ADDR ? en_r : q_bus.addr == IRQ_PEND_ADDR ? pend_r :
                rx_hit ? {8'ha5, rx_seq_r + 8'(rx_first), q_bus.addr[15:0]} : 32'h0;
        end else begin
            q_rdata <= ~q_rdata;
        end
    end
    always @(posedge clk) begin
        if (q_bus.wr && q_bus.rd) begin
            bad++;
        end
        if (tx_hit) begin
            tx_words++;
            tx_mem[q_bus.addr[5:2]] <= q_bus.wdata;
            if (!tx_first && q_bus.addr[5:0] != {tx_idx_r + 4'h1, 2'h0}) begin
                bad++;
            end
            tx_idx_r <= q_bus.addr[5:2];
        end
        if (rx_hit) begin
            rx_words++;
            if (!rx_first && q_bus.addr[5:0] != {rx_idx_r + 4'h1, 2'h0}) begin
                bad++;
            end
            rx_idx_r <= q_bus.addr[5:2];
        end
    end
endmodule

/* File: testbench/acq_host_tb_top.sv */
// Self-checking bench for the cell queue servicing controller.
`timescale 1ns/10ps
module acq_host_tb_top;
    import acq_pkg::*;
    typedef struct packed {
        logic [4:0] ctrl;
        logic [7:0] ntx;
    } acq_row_t;
    localparam acq_row_t ROWS [7] = '{'{5'h03, 8'h01}, '{5'h0b, 8'h02}, '{5'h13, 8'h01},
        '{5'h1b, 8'h00}, '{5'h07, 8'h01}, '{5'h0f, 8'h01}, '{5'h17, 8'h02}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    acq_sw_t sw = '0;
    logic [31:0] sw_rdata;
    acq_qbus_t q_bus;
    logic [31:0] q_rdata;
    logic tx_room = 1'b1;
    logic rx_push = 1'b0;
    logic tx_evt;
    logic rx_evt;
    logic irq;
    logic [31:0] rd_v;
    int errors = 0;
    int samples_checked = 0;
    int rx_seq = 0;
    int words;
    int tx0;
    int rx0;
    acq_host i_acq_host (.CORE_CLK(clk), .RST_N(rst_n), .SW(sw), .SW_RDATA(sw_rdata),
        .Q_BUS(q_bus), .Q_RDATA(q_rdata), .TX_QUEUE_EVENT(tx_evt), .RX_QUEUE_EVENT(rx_evt),
        .QUEUE_CPU_INTERRUPT(irq));
    acq_dev_model i_acq_dev_model (.clk(clk), .rst_n(rst_n), .q_bus(q_bus), .q_rdata(q_rdata),
        .tx_room(tx_room), .rx_push(rx_push), .tx_evt(tx_evt), .rx_evt(rx_evt), .irq(irq));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic sw_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        sw <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        sw <= '0;
    endtask
    task automatic sw_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        sw <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        sw <= '0;
        #1 d = sw_rdata;
    endtask
    // Polls the status register until the masked bits match, within a bounded count.
    task automatic poll(input logic [31:0] mask, input logic [31:0] val);
        for (int i = 0; i < 300; i++) begin
            sw_rd(REG_STAT, rd_v);
            if ((rd_v & mask) === val) return;
        end
        chk("status wait", rd_v & mask, val);
    endtask
    function automatic int words_of(input logic [4:0] c);
        return c[4:3] == 2'h0 ? 14 : c[4:3] == 2'h1 ? 15 : 16;
    endfunction
    task give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        give_verdict;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 16; i++) sw_wr(8'h40 + 8'(4 * i), 32'h7700_0000 + 32'(i));
        foreach (ROWS[r]) begin
            words = words_of(ROWS[r].ctrl);
            tx0 = i_acq_dev_model.tx_words;
            rx0 = i_acq_dev_model.rx_words;
            sw_wr(REG_CTRL, 32'(ROWS[r].ctrl));
            sw_wr(REG_TXCNT, 32'(ROWS[r].ntx));
            rx_push <= 1'b1;
            @(posedge clk);
            rx_push <= 1'b0;
            rx_seq++;
            poll(32'h0000_ff01, 32'h0000_0001);
            chk("tx words", 32'(i_acq_dev_model.tx_words - tx0), 32'(words * ROWS[r].ntx));
            chk("rx words", 32'(i_acq_dev_model.rx_words - rx0), 32'(words));
            chk("enable reg", i_acq_dev_model.en_r, ROWS[r].ctrl[2] ? 32'h0001_0001 : 32'h0);
            chk("rx pending", 32'(i_acq_dev_model.pend_r[16]), 32'(!ROWS[r].ctrl[2]));
            chk("irq line", 32'(irq), 32'(ROWS[r].ctrl[2]));
            chk("bus form", 32'(i_acq_dev_model.bad), 32'h0);
            sw_rd(8'h80, rd_v);
            chk("rx first", rd_v, {8'ha5, 8'(rx_seq), 16'h0});
            sw_rd(8'h80 + 8'(4 * (words - 1)), rd_v);
            chk("rx last", rd_v, {8'ha5, 8'(rx_seq), 16'(4 * (words - 1))});
            if (ROWS[r].ntx != 8'h00) begin
                chk("tx last", i_acq_dev_model.tx_mem[words - 1], 32'h7700_0000 + 32'(words - 1));
            end
            sw_wr(REG_RXACK, 32'h1);
        end
        sw_rd(REG_STAT, rd_v);
        chk("rx cells", rd_v & 32'h00ff_0000, {8'h0, 8'($size(ROWS)), 16'h0});
        // Transmit must wait while the queue has no room for a cell.
        tx_room <= 1'b0;
        repeat (8) @(posedge clk);
        tx0 = i_acq_dev_model.tx_words;
        sw_wr(REG_CTRL, 32'h01);
        sw_wr(REG_TXCNT, 32'h1);
        repeat (20) @(posedge clk);
        chk("tx held", 32'(i_acq_dev_model.tx_words - tx0), 32'h0);
        tx_room <= 1'b1;
        poll(32'h0000_ff02, 32'h0);
        chk("tx resumed", 32'(i_acq_dev_model.tx_words - tx0), 32'd14);
        // Reset in the middle of a cell.
        tx0 = i_acq_dev_model.tx_words;
        sw_wr(REG_TXCNT, 32'h3);
        for (int i = 0; i < 200 && i_acq_dev_model.tx_words < tx0 + 5; i++) @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        #1 chk("bus in reset", q_bus.addr | {30'h0, q_bus.wr, q_bus.rd}, 32'h0);
        @(posedge clk);
        rst_n <= 1'b1;
        sw_wr(8'hf0, 32'hffff_ffff);
        sw_rd(REG_CTRL, rd_v);
        chk("ctrl after reset", rd_v, 32'(CTRL_RST));
        sw_rd(REG_STAT, rd_v);
        chk("stat after reset", rd_v, 32'h0);
        sw_rd(8'hf0, rd_v);
        chk("unmapped", rd_v, 32'h0);
        chk("enable after reset", i_acq_dev_model.en_r, 32'h0);
        give_verdict;
    end
endmodule
